/* hdl/touch_measure_pkg.sv */
// Purpose: Shared constants and types of the touch measurement controller
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Offsets are byte addresses
package touch_measure_pkg;

  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] MEAS_CFG_ADDR = 8'h04;
  localparam logic [7:0] TRIM_ADDR = 8'h08;
  localparam logic [7:0] STATE_ADDR = 8'h0C;
  localparam logic [7:0] SENSOR_COUNT_ADDR = 8'h10;
  localparam logic [7:0] REF_COUNT_ADDR = 8'h14;
  localparam logic [7:0] EVT_STATUS_ADDR = 8'h18;
  localparam logic [7:0] EVT_CLEAR_ADDR = 8'h1C;
  localparam logic [7:0] EVT_ENABLE_ADDR = 8'h20;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HF_OFF_BIT = 1;
  localparam int CTRL_SUPPLY_TUNE_BIT = 2;
  localparam int CTRL_LEVEL_TUNE_BIT = 3;
  localparam int CTRL_CLKSEL_LSB = 4;
  localparam int CTRL_PORTS_LSB = 8;

  // Per-port measurement configuration fields
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_NUM_LSB = 8;
  localparam int CFG_MODE_LSB = 16;
  localparam int CFG_RATIO_LSB = 20;

  // Trim fields
  localparam int TRIM_REF_LSB = 0;
  localparam int TRIM_OFS_LSB = 16;

  // Event bits
  localparam int EVT_FINISH = 0;
  localparam int EVT_SENSOR_OVF = 1;
  localparam int EVT_REF_OVF = 2;
  localparam int EVT_HOLD_ERR = 3;
  localparam int EVT_W = 4;

  // Reset values
  localparam logic [7:0] DIV_RESET = 8'h1F;
  localparam logic [1:0] CLKSEL_RESET = 2'h1;
  localparam logic [1:0] MODE_RESET = 2'h2;
  localparam logic [3:0] RATIO_RESET = 4'h3;
  localparam logic [9:0] REF_CURRENT_TRIM_POINT = 10'h3FF;

  // Base pulse number per mode
  localparam logic [9:0] BASE_PULSES_MODE0 = 10'h1FE;
  localparam logic [9:0] BASE_PULSES_MODE1 = 10'h07E;
  localparam logic [9:0] BASE_PULSES_MODE2 = 10'h03E;
  localparam logic [9:0] BASE_PULSES_MODE3 = 10'h01E;

  typedef enum logic [1:0] {
    IDLE,
    SETUP,
    MEASURE,
    RESULT
  } fsm_type;

endpackage

/* hdl/drive_divider.sv */
// Purpose: Count-source prescaler and drive-pulse divider
// Assumes: Single clock, run low holds the dividers at phase zero
// Notes: Base period is div+1 count-source ticks
`timescale 1ns/1ps
`default_nettype none
module drive_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic [7:0] div,
  // Outputs
  output logic cs_tick,
  output logic drive_out
);
  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] drv;
    logic lvl;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;
  logic [2:0] lim;

  assign cs_tick = run && (s_r.pre == lim);
  assign drive_out = s_r.lvl;

  always_comb begin
    lim = 3'((4'h1 << sel) - 4'h1);
    s_nxt = s_r;
    if (!run) begin
      s_nxt = '0;
    end else if (s_r.pre == lim) begin
      s_nxt.pre = 3'h0;
      s_nxt.drv = (s_r.drv == div) ? 8'h00 : s_r.drv + 8'h01;
      s_nxt.lvl = (s_nxt.drv <= (div >> 1));
    end else begin
      s_nxt.pre = s_r.pre + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // drive_divider
`default_nettype wire

/* hdl/sat_counter.sv */
// Purpose: Oscillator pulse counter that sticks at all ones
// Assumes: inc is one pulse per oscillator edge, synchronous to pclk
// Notes: ovf pulses on every increment that arrives while the count is all ones and clear is low
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic inc,
  // Outputs
  output logic [W-1:0] count,
  output logic ovf
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_type;

  cnt_state_type s_r;
  cnt_state_type s_nxt;

  assign count = s_r.cnt;
  assign ovf = inc && !clear && (&s_r.cnt);

  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.cnt = '0;
    end else if (inc && !(&s_r.cnt)) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sat_counter
`default_nettype wire

/* hdl/cap_touch_measure_ctrl.sv */
// Purpose: Control of the capacitive touch measurement unit
// Assumes: Oscillator ticks and underflow are synchronous to pclk
// Notes: DMA reaches the registers over APB like software
// Function
// - Base clock from prescaler then drive divider
// - Divider reloadable per port by transfer
// - Repeat base pulse group by ratio
// - Duration follows pulses, count, quarter term, repeats
// - Count field per port; zero measures once
// - Count both oscillators into readable results
// - Overflow saturates at 0xFFFF and flags
// - Mode 10B gives 62 base pulses
// - Bit disables high-frequency noise immunity
// - Sensor offset current field, zero none
// - Reference current setting, 0x3FF trim point
// - Flag measurement during sensor oscillator underflow
// - Results to memory, then finish interrupt
`timescale 1ns/1ps
`default_nettype none
module cap_touch_measure_ctrl #(
  parameter int PORTS_W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [touch_measure_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator front end
  input wire logic sensor_osc_tick,
  input wire logic ref_osc_tick,
  input wire logic sensor_osc_underflow,
  // Analog controls
  output logic drive_out,
  output logic measure_active,
  output logic hf_noise_immunity_off,
  output logic supply_range_tune,
  output logic output_level_tune,
  output logic [9:0] reference_current_set,
  output logic [6:0] sensor_offset_current,
  // Transfer requests and interrupt
  output logic dma_setup_req,
  output logic dma_result_req,
  output logic irq
);
  import touch_measure_pkg::*;

  typedef struct packed {
    fsm_type fsm;
    logic [PORTS_W-1:0] port;
    logic [PORTS_W-1:0] last_port;
    logic [1:0] count_source_select;
    logic hf_off;
    logic supply_tune;
    logic level_tune;
    logic [7:0] drive_pulse_divider;
    logic [7:0] measure_count;
    logic [1:0] base_pulse_mode;
    logic [3:0] cycle_repeat_ratio;
    logic [9:0] ref_set;
    logic [6:0] ofs_set;
    logic [31:0] timer;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_en;
    logic [31:0] rdata;
  } ctrl_state_type;

  ctrl_state_type s_r;
  ctrl_state_type s_nxt;

  logic cs_tick;
  logic clr_cnt;
  logic measuring;
  logic [CNT_W-1:0] sensor_count;
  logic [CNT_W-1:0] ref_count;
  logic sensor_ovf;
  logic ref_ovf;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [9:0] base_pulses;
  logic [31:0] pulses_ext;
  logic [31:0] div_ext;
  logic [31:0] per_group;
  logic [31:0] target;
  logic [31:0] rd_val;

  assign measuring = (s_r.fsm == MEASURE);
  assign clr_cnt = (s_r.fsm == SETUP) && wr_en && (paddr == MEAS_CFG_ADDR);

  drive_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(measuring),
    .sel(s_r.count_source_select),
    .div(s_r.drive_pulse_divider),
    .cs_tick(cs_tick),
    .drive_out(drive_out)
  );

  sat_counter #(.W(CNT_W)) u_sensor_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clr_cnt),
    .inc(measuring && sensor_osc_tick),
    .count(sensor_count),
    .ovf(sensor_ovf)
  );

  sat_counter #(.W(CNT_W)) u_ref_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clr_cnt),
    .inc(measuring && ref_osc_tick),
    .count(ref_count),
    .ovf(ref_ovf)
  );

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = s_r.rdata;
  assign pslverr = psel && penable && !mapped;

  assign measure_active = measuring;
  assign hf_noise_immunity_off = s_r.hf_off;
  assign supply_range_tune = s_r.supply_tune;
  assign output_level_tune = s_r.level_tune;
  assign reference_current_set = s_r.ref_set;
  assign sensor_offset_current = s_r.ofs_set;
  assign dma_setup_req = (s_r.fsm == SETUP);
  assign dma_result_req = (s_r.fsm == RESULT);
  assign irq = |(s_r.evt & s_r.evt_en);

  // Address decode and read data
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      CTRL_ADDR: begin
        rd_val[CTRL_HF_OFF_BIT] = s_r.hf_off;
        rd_val[CTRL_SUPPLY_TUNE_BIT] = s_r.supply_tune;
        rd_val[CTRL_LEVEL_TUNE_BIT] = s_r.level_tune;
        rd_val[CTRL_CLKSEL_LSB +: 2] = s_r.count_source_select;
        rd_val[CTRL_PORTS_LSB +: PORTS_W] = s_r.last_port;
      end
      MEAS_CFG_ADDR: begin
        rd_val[CFG_DIV_LSB +: 8] = s_r.drive_pulse_divider;
        rd_val[CFG_NUM_LSB +: 8] = s_r.measure_count;
        rd_val[CFG_MODE_LSB +: 2] = s_r.base_pulse_mode;
        rd_val[CFG_RATIO_LSB +: 4] = s_r.cycle_repeat_ratio;
      end
      TRIM_ADDR: begin
        rd_val[TRIM_REF_LSB +: 10] = s_r.ref_set;
        rd_val[TRIM_OFS_LSB +: 7] = s_r.ofs_set;
      end
      STATE_ADDR: begin
        rd_val[1:0] = s_r.fsm;
        rd_val[8 +: PORTS_W] = s_r.port;
      end
      SENSOR_COUNT_ADDR: begin
        rd_val[CNT_W-1:0] = sensor_count;
      end
      REF_COUNT_ADDR: begin
        rd_val[CNT_W-1:0] = ref_count;
      end
      EVT_STATUS_ADDR: begin
        rd_val[EVT_W-1:0] = s_r.evt;
      end
      EVT_CLEAR_ADDR: begin
        rd_val = 32'h0000_0000;
      end
      EVT_ENABLE_ADDR: begin
        rd_val[EVT_W-1:0] = s_r.evt_en;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Measurement length in count-source ticks
  always_comb begin
    case (s_r.base_pulse_mode)
      2'h0: base_pulses = BASE_PULSES_MODE0;
      2'h1: base_pulses = BASE_PULSES_MODE1;
      2'h2: base_pulses = BASE_PULSES_MODE2;
      default: base_pulses = BASE_PULSES_MODE3;
    endcase
    pulses_ext = {22'h000000, base_pulses};
    div_ext = {24'h000000, s_r.drive_pulse_divider} + 32'h0000_0001;
    per_group = pulses_ext * ({24'h000000, s_r.measure_count} + 32'h0000_0001) * div_ext
      + (((pulses_ext - 32'h0000_0002) * div_ext) >> 2);
    target = per_group * ((s_r.cycle_repeat_ratio == 4'h0) ? 32'h0000_0001 :
      {28'h0000000, s_r.cycle_repeat_ratio});
  end

  // Control, sequencing and events
  always_comb begin
    s_nxt = s_r;
    if (psel && !penable) begin
      s_nxt.rdata = rd_val;
    end
    if (wr_en) begin
      case (paddr)
        CTRL_ADDR: begin
          s_nxt.hf_off = pwdata[CTRL_HF_OFF_BIT];
          s_nxt.supply_tune = pwdata[CTRL_SUPPLY_TUNE_BIT];
          s_nxt.level_tune = pwdata[CTRL_LEVEL_TUNE_BIT];
          if (s_r.fsm == IDLE) begin
            s_nxt.count_source_select = pwdata[CTRL_CLKSEL_LSB +: 2];
            s_nxt.last_port = pwdata[CTRL_PORTS_LSB +: PORTS_W];
            if (pwdata[CTRL_START_BIT]) begin
              s_nxt.fsm = SETUP;
              s_nxt.port = '0;
            end
          end
        end
        MEAS_CFG_ADDR: begin
          if (s_r.fsm == IDLE || s_r.fsm == SETUP) begin
            s_nxt.drive_pulse_divider = pwdata[CFG_DIV_LSB +: 8];
            s_nxt.measure_count = pwdata[CFG_NUM_LSB +: 8];
            s_nxt.base_pulse_mode = pwdata[CFG_MODE_LSB +: 2];
            s_nxt.cycle_repeat_ratio = pwdata[CFG_RATIO_LSB +: 4];
          end
          if (s_r.fsm == SETUP) begin
            s_nxt.fsm = MEASURE;
            s_nxt.timer = 32'h0000_0000;
          end
        end
        TRIM_ADDR: begin
          s_nxt.ref_set = pwdata[TRIM_REF_LSB +: 10];
          s_nxt.ofs_set = pwdata[TRIM_OFS_LSB +: 7];
        end
        EVT_CLEAR_ADDR: begin
          s_nxt.evt = s_r.evt & ~pwdata[EVT_W-1:0];
        end
        EVT_ENABLE_ADDR: begin
          s_nxt.evt_en = pwdata[EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    case (s_r.fsm)
      IDLE: begin
      end
      SETUP: begin
      end
      MEASURE: begin
        if (cs_tick) begin
          if (s_r.timer >= target - 32'h0000_0001) begin
            s_nxt.fsm = RESULT;
          end else begin
            s_nxt.timer = s_r.timer + 32'h0000_0001;
          end
        end
      end
      RESULT: begin
        if (rd_en && paddr == REF_COUNT_ADDR) begin
          if (s_r.port == s_r.last_port) begin
            s_nxt.fsm = IDLE;
            s_nxt.evt[EVT_FINISH] = 1'b1;
          end else begin
            s_nxt.fsm = SETUP;
            s_nxt.port = s_r.port + 1'b1;
          end
        end
      end
      default: begin
        s_nxt.fsm = IDLE;
      end
    endcase
    // Hardware sets win over a clear in the same cycle
    if (sensor_ovf) begin
      s_nxt.evt[EVT_SENSOR_OVF] = 1'b1;
    end
    if (ref_ovf) begin
      s_nxt.evt[EVT_REF_OVF] = 1'b1;
    end
    if (measuring && sensor_osc_underflow) begin
      s_nxt.evt[EVT_HOLD_ERR] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.fsm <= IDLE;
      s_r.count_source_select <= CLKSEL_RESET;
      s_r.drive_pulse_divider <= DIV_RESET;
      s_r.base_pulse_mode <= MODE_RESET;
      s_r.cycle_repeat_ratio <= RATIO_RESET;
      s_r.ref_set <= REF_CURRENT_TRIM_POINT;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // cap_touch_measure_ctrl
`default_nettype wire

/* verification/cap_touch_measure_ctrl_chk.sv */
// Purpose: Port checker of the touch control
// Assumes: Bound to the top module
// Notes: One clock domain
`timescale 1ns/1ps
`default_nettype none
module cap_touch_measure_ctrl_chk #(
  parameter int PORTS_W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [touch_measure_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Outputs
  input wire logic drive_out,
  input wire logic measure_active,
  input wire logic hf_noise_immunity_off,
  input wire logic [9:0] reference_current_set,
  input wire logic [6:0] sensor_offset_current,
  input wire logic dma_setup_req,
  input wire logic dma_result_req,
  input wire logic irq
);
  import touch_measure_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic [31:0] wd_q;
  logic [16:0] mlen_q;
  assign wr_acc = psel && penable && pwrite;
  always_ff @(posedge pclk) begin
    wd_q <= pwdata;
  end
  // Measure cycles of the current port bound both counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mlen_q <= 17'h00000;
    end else if (dma_setup_req) begin
      mlen_q <= 17'h00000;
    end else if (measure_active && mlen_q != 17'h1FFFF) begin
      mlen_q <= mlen_q + 17'h00001;
    end
  end
  property p_cfg_start;
    wr_acc && paddr == MEAS_CFG_ADDR && dma_setup_req |=> measure_active && !dma_setup_req;
  endproperty
  a_cfg_start: assert property (p_cfg_start) else $error("Setup write did not start");
  property p_min_len;
    $rose(measure_active) |-> measure_active [*8];
  endproperty
  a_min_len: assert property (p_min_len) else $error("Measurement too short");
  property p_drive_idle;
    !measure_active && !$past(measure_active) |-> !drive_out;
  endproperty
  a_drive_idle: assert property (p_drive_idle) else $error("Drive active when idle");
  property p_hf_off;
    wr_acc && paddr == CTRL_ADDR |=> hf_noise_immunity_off == wd_q[CTRL_HF_OFF_BIT];
  endproperty
  a_hf_off: assert property (p_hf_off) else $error("Noise bit not taken");
  property p_offset;
    wr_acc && paddr == TRIM_ADDR |=> sensor_offset_current == wd_q[22:16];
  endproperty
  a_offset: assert property (p_offset) else $error("Offset not taken");
  property p_ref_set;
    wr_acc && paddr == TRIM_ADDR |=> reference_current_set == wd_q[9:0];
  endproperty
  a_ref_set: assert property (p_ref_set) else $error("Reference not taken");
  property p_ref_rst;
    $rose(presetn) |-> reference_current_set == REF_CURRENT_TRIM_POINT;
  endproperty
  a_ref_rst: assert property (p_ref_rst) else $error("Reference reset wrong");
  property p_cnt_width;
    psel && penable && !pwrite && paddr == SENSOR_COUNT_ADDR |-> prdata[31:16] == 16'h0000;
  endproperty
  a_cnt_width: assert property (p_cnt_width) else $error("Count wider than 16");
  property p_cnt_bound;
    psel && penable && !pwrite && dma_result_req && (paddr == SENSOR_COUNT_ADDR || paddr == REF_COUNT_ADDR)
      |-> {1'b0, prdata[15:0]} <= mlen_q;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("Count exceeds port period");
  property p_result;
    $rose(dma_result_req) |-> $past(measure_active);
  endproperty
  a_result: assert property (p_result) else $error("Result without measure");
  c_result: cover property ($rose(dma_result_req));
  c_irq: cover property ($rose(irq));
  c_trim: cover property (wr_acc && paddr == TRIM_ADDR);
endmodule // cap_touch_measure_ctrl_chk
bind cap_touch_measure_ctrl cap_touch_measure_ctrl_chk #(.PORTS_W(PORTS_W)) chk_inst (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .drive_out(drive_out), .measure_active(measure_active),
  .hf_noise_immunity_off(hf_noise_immunity_off), .reference_current_set(reference_current_set),
  .sensor_offset_current(sensor_offset_current), .dma_setup_req(dma_setup_req),
  .dma_result_req(dma_result_req), .irq(irq));
`default_nettype wire

/* verification/osc_front_model.sv */
// Purpose: Oscillator front end stand-in
// Assumes: Ticks synchronous to pclk
// Notes: Ticks run also outside measurement
`timescale 1ns/1ps
`default_nettype none
module osc_front_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Mode
  input wire logic full_rate,
  input wire logic uflow_req,
  // Oscillator outputs
  output logic sensor_osc_tick,
  output logic ref_osc_tick,
  output logic sensor_osc_underflow
);
  logic [15:0] lfsr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 16'hACE1;
      sensor_osc_tick <= 1'b0;
      ref_osc_tick <= 1'b0;
      sensor_osc_underflow <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      sensor_osc_tick <= full_rate | lfsr_r[0];
      ref_osc_tick <= full_rate | lfsr_r[5];
      sensor_osc_underflow <= uflow_req;
    end
  end
endmodule // osc_front_model
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench of the touch control
// Assumes: Zero wait APB, one clock
// Notes: Reads queue their expected words
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import touch_measure_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, full = 1'b0, uf = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, e, rnd;
  logic pready, pslverr, so_t, ro_t, so_u, drv, act, hfo, sup, lvl, dsr, drr, irq;
  logic [9:0] rcs;
  logic [6:0] soc;
  int bad_count = 0, total_checks = 0, sc, rc, mc;
  logic [31:0] q[$];
  always #10 pclk = ~pclk;
  cap_touch_measure_ctrl cap_touch_measure_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensor_osc_tick(so_t), .ref_osc_tick(ro_t), .sensor_osc_underflow(so_u),
    .drive_out(drv), .measure_active(act), .hf_noise_immunity_off(hfo), .supply_range_tune(sup),
    .output_level_tune(lvl), .reference_current_set(rcs), .sensor_offset_current(soc),
    .dma_setup_req(dsr), .dma_result_req(drr), .irq(irq));
  osc_front_model osc_front_model_inst (.pclk(pclk), .presetn(presetn), .full_rate(full),
    .uflow_req(uf), .sensor_osc_tick(so_t), .ref_osc_tick(ro_t), .sensor_osc_underflow(so_u));
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      `CHK(prdata, e)
      `CHK(pslverr, paddr == 8'h24)
    end
  end
  always @(posedge pclk) begin
    if (dsr === 1'b1) begin
      sc <= 0;
      rc <= 0;
      mc <= 0;
    end else if (act === 1'b1) begin
      sc <= sc + so_t;
      rc <= rc + ro_t;
      mc <= mc + 1;
    end
  end
  task automatic complete_run(input bit hung);
    if (hung) bad_count++;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) complete_run(1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic meas(input int d, input int n, input int m, input int r, input int s);
    int p, c;
    p = m == 0 ? 510 : m == 1 ? 126 : m == 2 ? 62 : 30;
    c = ((p * (n + 1) * (d + 1) + (((p - 2) * (d + 1)) >> 2)) * (r == 0 ? 1 : r)) << s;
    wr(MEAS_CFG_ADDR, {8'h00, r[3:0], 2'b00, m[1:0], n[7:0], d[7:0]});
    for (int i = 0; i < 70000 && drr !== 1'b1; i++) @(posedge pclk);
    if (drr !== 1'b1) complete_run(1);
    `CHK(mc >= c - 2 && mc <= c + (1 << s) + 2, 1'b1)
    rd(SENSOR_COUNT_ADDR, sc > 65535 ? 32'hFFFF : sc);
    rd(REF_COUNT_ADDR, rc > 65535 ? 32'hFFFF : rc);
  endtask
  initial begin
    void'($urandom(3583));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(rcs, 10'h3FF)
    `CHK(irq, 1'b0)
    rnd = $urandom;
    wr(TRIM_ADDR, {9'h0, rnd[6:0], 6'h0, rnd[25:16]});
    `CHK(rcs, rnd[25:16])
    `CHK(soc, rnd[6:0])
    wr(TRIM_ADDR, 32'h3FF);
    `CHK(soc, 7'h00)
    wr(CTRL_ADDR, 32'h31E);
    `CHK(hfo, 1'b1)
    `CHK({sup, lvl}, 2'b11)
    wr(EVT_ENABLE_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h31F);
    rd(STATE_ADDR, 32'h1);
    for (int i = 0; i < 4; i++) begin
      uf <= (i == 2);
      meas(i & 1, i >> 1, 3 - i, i, 1);
    end
    uf <= 1'b0;
    `CHK(irq, 1'b1)
    rd(EVT_STATUS_ADDR, 32'h9);
    wr(EVT_CLEAR_ADDR, 32'hF);
    `CHK(irq, 1'b0)
    wr(EVT_ENABLE_ADDR, 32'h6);
    full <= 1'b1;
    wr(CTRL_ADDR, 32'h001);
    `CHK({hfo, sup, lvl}, 3'b000)
    meas(0, 128, 0, 1, 0);
    `CHK(irq, 1'b1)
    wr(EVT_ENABLE_ADDR, 32'h0);
    `CHK(irq, 1'b0)
    rd(EVT_STATUS_ADDR, 32'h7);
    wr(EVT_CLEAR_ADDR, 32'h7);
    rd(EVT_STATUS_ADDR, 32'h0);
    rd(8'h24, 32'h0);
    complete_run(0);
  end
endmodule // tb_top
`default_nettype wire
